// File: nvsc_regs.vh
// constants for the nonvolatile sram host controller
`ifndef NVSC_REGS_VH
`define NVSC_REGS_VH
`define NVSC_ADDR_W        15
`define NVSC_MATCH_W       14
`define NVSC_SEQ_A0        14'h0e38
`define NVSC_SEQ_A1        14'h31c7
`define NVSC_SEQ_A2        14'h03e0
`define NVSC_SEQ_A3        14'h3c1f
`define NVSC_SEQ_A4        14'h303f
`define NVSC_SEQ_SAVE      14'h0fc0
`define NVSC_SEQ_RELOAD    14'h0c63
`define NVSC_CLK_MHZ       100
`define NVSC_SAVE_MS       10
`define NVSC_RELOAD_US     20
`define NVSC_PWRUP_US      550
`define NVSC_SAVE_CYC      (`NVSC_SAVE_MS * 1000 * `NVSC_CLK_MHZ)
`define NVSC_RELOAD_CYC    (`NVSC_RELOAD_US * `NVSC_CLK_MHZ)
`define NVSC_PWRUP_CYC     (`NVSC_PWRUP_US * `NVSC_CLK_MHZ)
`define NVSC_CYC_W         24
`define NVSC_CMD_READ      3'h0
`define NVSC_CMD_WRITE     3'h1
`define NVSC_CMD_SAVE      3'h2
`define NVSC_CMD_RELOAD    3'h3
`endif

// File: nvsc_wait.v
// busy timer: holds busy for a loaded count of clock cycles
`timescale 1ns/1ps
`default_nettype none
module nvsc_wait #(
    parameter W = 24
) (
    // clock and reset
    input  wire         mclk_i,
    input  wire         rst_n_i,
    // control
    input  wire         load_i,
    input  wire [W-1:0] count_i,
    // status
    output wire         busy_o
);
    reg [W-1:0] cnt_q;
    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= {W{1'b0}};
        else if (load_i)
            cnt_q <= count_i;
        else if (cnt_q != {W{1'b0}})
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
    assign busy_o = (cnt_q != {W{1'b0}});
endmodule
`default_nettype wire

// File: nvsc_ctrl.v
// host controller for a byte-wide sram with nonvolatile save and reload
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_regs.vh"
module nvsc_ctrl #(
    parameter SAVE_CYC   = `NVSC_SAVE_CYC,
    parameter RELOAD_CYC = `NVSC_RELOAD_CYC,
    parameter PWRUP_CYC  = `NVSC_PWRUP_CYC
) (
    // clock and reset
    input  wire        mclk_i,
    input  wire        rst_n_i,
    // command port
    input  wire        cmd_valid_i,
    input  wire [2:0]  cmd_op_i,
    input  wire [14:0] cmd_addr_i,
    input  wire [7:0]  cmd_wdata_i,
    input  wire        low_supply_i,
    output reg         cmd_ready_o,
    output reg         rsp_valid_o,
    output reg  [7:0]  rsp_rdata_o,
    output reg         cmd_err_o,
    // memory pins
    output reg         chip_sel_n_o,
    output reg         wr_strobe_n_o,
    output reg         out_gate_n_o,
    output reg  [14:0] byte_address_bus_o,
    output reg  [7:0]  bidir_data_lines_o,
    output reg         bidir_data_lines_oe_o,
    input  wire [7:0]  bidir_data_lines_i
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_SETUP = 3'd1;
    localparam ST_STRB  = 3'd2;
    localparam ST_END   = 3'd3;
    localparam ST_WAIT  = 3'd4;
    localparam ST_PWRUP = 3'd5;

    reg  [2:0]  state_q;
    reg  [2:0]  op_q;
    reg  [2:0]  step_q;
    reg         seq_q;
    reg  [7:0]  wdata_q;
    reg  [14:0] addr_q;
    reg         dirty_q;
    reg         load;
    reg  [23:0] load_cnt;
    wire        busy;
    wire        is_write;
    wire        is_nv;

    // one timer serves power-up, save and reload waits
    nvsc_wait #(
        .W       (`NVSC_CYC_W)
    ) u_wait (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .load_i  (load),
        .count_i (load_cnt),
        .busy_o  (busy)
    );

    assign is_write = (op_q == `NVSC_CMD_WRITE);
    assign is_nv    = (op_q == `NVSC_CMD_SAVE) ||
                      (op_q == `NVSC_CMD_RELOAD);

    // sixth address selects save or reload; top bit left zero
    function [14:0] seq_addr;
        input [2:0] step;
        input       reload;
        begin
            case (step)
                3'd0:    seq_addr = {1'b0, `NVSC_SEQ_A0};
                3'd1:    seq_addr = {1'b0, `NVSC_SEQ_A1};
                3'd2:    seq_addr = {1'b0, `NVSC_SEQ_A2};
                3'd3:    seq_addr = {1'b0, `NVSC_SEQ_A3};
                3'd4:    seq_addr = {1'b0, `NVSC_SEQ_A4};
                default: seq_addr = reload ?
                                    {1'b0, `NVSC_SEQ_RELOAD} :
                                    {1'b0, `NVSC_SEQ_SAVE};
            endcase
        end
    endfunction

    always @*
    begin
        load     = 1'b0;
        load_cnt = 24'h00_0000;
        if (state_q == ST_END && seq_q && step_q == 3'd5)
        begin
            load     = 1'b1;
            load_cnt = (op_q == `NVSC_CMD_RELOAD) ?
                       RELOAD_CYC[23:0] : SAVE_CYC[23:0];
        end
        else if (state_q == ST_PWRUP && !busy && !seq_q)
        begin
            load     = 1'b1;
            load_cnt = PWRUP_CYC[23:0];
        end
    end

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q               <= ST_PWRUP;
            op_q                  <= 3'h0;
            step_q                <= 3'h0;
            seq_q                 <= 1'b0;
            wdata_q               <= 8'h00;
            addr_q                <= 15'h0000;
            dirty_q               <= 1'b0;
            cmd_ready_o           <= 1'b0;
            rsp_valid_o           <= 1'b0;
            rsp_rdata_o           <= 8'h00;
            cmd_err_o             <= 1'b0;
            chip_sel_n_o          <= 1'b1;
            wr_strobe_n_o         <= 1'b1;
            out_gate_n_o          <= 1'b1;
            byte_address_bus_o    <= 15'h0000;
            bidir_data_lines_o    <= 8'h00;
            bidir_data_lines_oe_o <= 1'b0;
        end
        else
        begin
            rsp_valid_o <= 1'b0;
            cmd_err_o   <= 1'b0;
            case (state_q)
                ST_PWRUP:
                begin
                    // seq_q marks the power-up timer as loaded
                    if (!seq_q)
                        seq_q <= 1'b1;
                    else if (!busy)
                    begin
                        seq_q       <= 1'b0;
                        state_q     <= ST_IDLE;
                        cmd_ready_o <= 1'b1;
                    end
                end
                ST_IDLE:
                begin
                    if (cmd_valid_i)
                    begin
                        cmd_ready_o <= 1'b0;
                        if (low_supply_i &&
                            (cmd_op_i == `NVSC_CMD_WRITE ||
                             cmd_op_i == `NVSC_CMD_SAVE))
                        begin
                            cmd_err_o   <= 1'b1;
                            rsp_valid_o <= 1'b1;
                            cmd_ready_o <= 1'b1;
                        end
                        else
                        begin
                            op_q    <= cmd_op_i;
                            wdata_q <= cmd_wdata_i;
                            addr_q  <= cmd_addr_i;
                            step_q  <= 3'h0;
                            // whole sequence runs unbroken
                            seq_q   <= (cmd_op_i == `NVSC_CMD_SAVE) ||
                                       (cmd_op_i == `NVSC_CMD_RELOAD);
                            state_q <= ST_SETUP;
                        end
                    end
                end
                ST_SETUP:
                begin
                    // address settles a cycle before chip select falls; the write strobe falls with the address
                    byte_address_bus_o <= seq_q ?
                        seq_addr(step_q, op_q == `NVSC_CMD_RELOAD) :
                        addr_q;
                    wr_strobe_n_o <= ~is_write;
                    bidir_data_lines_o    <= wdata_q;
                    bidir_data_lines_oe_o <= is_write;
                    state_q <= ST_STRB;
                end
                ST_STRB:
                begin
                    // one chip select fall per step, no double clocking
                    chip_sel_n_o <= 1'b0;
                    // gate held off in nv sequence, device floats step six
                    out_gate_n_o <= is_write | is_nv;
                    state_q <= ST_END;
                end
                ST_END:
                begin
                    rsp_rdata_o           <= bidir_data_lines_i;
                    chip_sel_n_o          <= 1'b1;
                    out_gate_n_o          <= 1'b1;
                    wr_strobe_n_o         <= 1'b1;
                    bidir_data_lines_oe_o <= 1'b0;
                    if (seq_q && step_q != 3'd5)
                    begin
                        step_q  <= step_q + 3'd1;
                        state_q <= ST_SETUP;
                    end
                    else if (seq_q)
                    begin
                        // a save clears dirty, as does a reload
                        dirty_q <= 1'b0;
                        seq_q   <= 1'b0;
                        step_q  <= 3'h0;
                        state_q <= ST_WAIT;
                    end
                    else
                    begin
                        if (is_write)
                            dirty_q <= 1'b1;
                        rsp_valid_o <= 1'b1;
                        cmd_ready_o <= 1'b1;
                        state_q     <= ST_IDLE;
                    end
                end
                ST_WAIT:
                begin
                    // no access reaches the device until the timer ends
                    if (!busy)
                    begin
                        rsp_valid_o <= 1'b1;
                        cmd_ready_o <= 1'b1;
                        state_q     <= ST_IDLE;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: nvsc_ctrl_asserts.sv
// checker for the controller's handshake and memory pins
`timescale 1ns/1ps
`default_nettype none
module nvsc_ctrl_chk (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        cmd_valid_i,
    input wire logic [2:0]  cmd_op_i,
    input wire logic        low_supply_i,
    input wire logic        cmd_ready_o,
    input wire logic        rsp_valid_o,
    input wire logic        cmd_err_o,
    input wire logic        chip_sel_n_o,
    input wire logic        wr_strobe_n_o,
    input wire logic        out_gate_n_o,
    input wire logic [14:0] byte_address_bus_o,
    input wire logic        bidir_data_lines_oe_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire tk = cmd_valid_i && cmd_ready_o;
    wire cs = !chip_sel_n_o;
    property p_rd;
        tk && cmd_op_i == 3'h0 |-> ##[1:4] (cs && !out_gate_n_o);
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe missing");
    property p_wr;
        tk && cmd_op_i == 3'h1 && !low_supply_i
            |-> ##[1:4] (cs && !wr_strobe_n_o && bidir_data_lines_oe_o);
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe missing");
    property p_ref;
        tk && low_supply_i && cmd_op_i inside {3'h1, 3'h2}
            |=> rsp_valid_o && cmd_err_o && !cs;
    endproperty
    a_ref: assert property (p_ref) else $error("low supply not refused");
    property p_cs1;
        $fell(chip_sel_n_o) |=> chip_sel_n_o;
    endproperty
    a_cs1: assert property (p_cs1) else $error("select held too long");
    property p_rdwe;
        cs && !out_gate_n_o |-> wr_strobe_n_o && !bidir_data_lines_oe_o;
    endproperty
    a_rdwe: assert property (p_rdwe) else $error("read with strobe low");
    property p_wrg;
        !wr_strobe_n_o |-> out_gate_n_o;
    endproperty
    a_wrg: assert property (p_wrg) else $error("gate open on write");
    property p_seq;
        tk && (cmd_op_i == 3'h3 || cmd_op_i == 3'h2 && !low_supply_i)
            |-> ##[1:4] (cs && byte_address_bus_o == 15'h0e38);
    endproperty
    a_seq: assert property (p_seq) else $error("bad first step");
    property p_seqwe;
        cs && out_gate_n_o && !bidir_data_lines_oe_o |-> wr_strobe_n_o;
    endproperty
    a_seqwe: assert property (p_seqwe) else $error("step with write");
    property p_adr;
        $fell(chip_sel_n_o) |-> $stable(byte_address_bus_o);
    endproperty
    a_adr: assert property (p_adr) else $error("address moved");
    c_rd: cover property (tk && cmd_op_i == 3'h0);
    c_sv: cover property (tk && cmd_op_i == 3'h2);
    c_err: cover property (cmd_err_o);
endmodule
bind nvsc_ctrl nvsc_ctrl_chk nvsc_ctrl_chk_i (.*);
`default_nettype wire

// File: nvsc_mem_model.sv
// behavioural sram with nonvolatile shadow, clocked by its strobes
`timescale 1ns/1ps
`default_nettype none
module nvsc_mem_model #(
    parameter BUSY_NS = 150
) (
    input  wire logic        cs_n_i,
    input  wire logic        we_n_i,
    input  wire logic        og_n_i,
    input  wire logic        low_i,
    input  wire logic [14:0] a_i,
    input  wire logic [7:0]  d_i,
    output var  logic [7:0]  q_o,
    output var  logic        q_oe_o
);
    logic [7:0]  mem [0:32767];
    logic [7:0]  nv  [0:32767];
    logic [13:0] sq  [0:6] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f,
                               14'h303f, 14'h0fc0, 14'h0c63};
    logic [2:0]  step = 3'h0;
    logic        busy = 1'b1;
    logic        hz = 1'b0;
    logic        wr_c = 1'b0;
    initial
    begin
        for (int i = 0; i < 32768; i++)
        begin
            mem[i] = 8'h00;
            nv[i] = 8'h00;
        end
        #BUSY_NS busy = 1'b0;
    end
    // undriven lines show the inverse so a stale byte cannot pass
    assign q_oe_o = !cs_n_i && !og_n_i && we_n_i && !wr_c && !busy && !hz;
    assign q_o = q_oe_o ? mem[a_i] : ~mem[a_i];
    always @(negedge cs_n_i)
    begin
        wr_c = !we_n_i;
        hz = 1'b0;
        if (busy)
            hz = 1'b1;
        else if (!we_n_i)
            step = 3'h0;
        else if (step == 3'h5 && a_i[13:0] == sq[5] && !low_i)
        begin
            hz = 1'b1;
            nv = mem;
            step = 3'h0;
            busy = 1'b1;
            busy <= #BUSY_NS 1'b0;
        end
        else if (step == 3'h5 && a_i[13:0] == sq[6])
        begin
            hz = 1'b1;
            mem = nv;
            step = 3'h0;
            busy = 1'b1;
            busy <= #BUSY_NS 1'b0;
        end
        else if (step < 3'h5 && a_i[13:0] == sq[step])
            step = step + 3'h1;
        else
            step = {2'b00, a_i[13:0] == sq[0]};
    end
    always @(posedge cs_n_i)
        if (wr_c && !busy && !low_i)
            mem[a_i] = d_i;
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the nonvolatile sram host controller
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_regs.vh"
module tb;
    logic        mclk_i = 0, rst_n_i = 0, cmd_valid_i = 0, low_supply_i = 0;
    logic [2:0]  cmd_op_i = 0;
    logic [14:0] cmd_addr_i = 0, ra;
    logic [7:0]  cmd_wdata_i = 0, rd;
    wire         rdy, rv, err, cs_n, we_n, og_n, oe;
    wire  [14:0] a;
    wire  [7:0]  rdat, dq_o, m_q, dq_i;
    logic [9:0]  exp_q [$];
    logic [9:0]  e;
    integer      failures = 0, n_checks = 0, cyc = 0, seed = 89, i;
    initial forever #5 mclk_i = ~mclk_i;
    assign dq_i = oe ? dq_o : m_q;
    nvsc_ctrl #(.SAVE_CYC(20), .RELOAD_CYC(20), .PWRUP_CYC(20)) nvsc_ctrl_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
        .cmd_wdata_i(cmd_wdata_i), .low_supply_i(low_supply_i),
        .cmd_ready_o(rdy), .rsp_valid_o(rv), .rsp_rdata_o(rdat),
        .cmd_err_o(err), .chip_sel_n_o(cs_n), .wr_strobe_n_o(we_n),
        .out_gate_n_o(og_n), .byte_address_bus_o(a),
        .bidir_data_lines_o(dq_o), .bidir_data_lines_oe_o(oe),
        .bidir_data_lines_i(dq_i));
    nvsc_mem_model nvsc_mem_model_i (.cs_n_i(cs_n), .we_n_i(we_n),
        .og_n_i(og_n), .low_i(low_supply_i), .a_i(a), .d_i(dq_o),
        .q_o(m_q), .q_oe_o());
    task check(input string nm, input [7:0] s, input [7:0] w);
        n_checks++;
        if (s !== w)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, w, s);
        end
    endtask
    task give_verdict;
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // note holds {compare data, refused, data}
    task go(input [2:0] op, input [14:0] ad, input [7:0] wd, input [9:0] ex);
        @(negedge mclk_i);
        while (rdy !== 1'b1)
            @(negedge mclk_i);
        @(posedge mclk_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i <= op;
        cmd_addr_i <= ad;
        cmd_wdata_i <= wd;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        exp_q.push_back(ex);
    endtask
    always @(posedge mclk_i)
        if (rv === 1'b1)
        begin
            e = exp_q.pop_front();
            check("refusal", {7'h00, err}, {7'h00, e[8]});
            if (e[9])
                check("read data", rdat, e[7:0]);
        end
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            give_verdict;
        end
    end
    initial
    begin
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 6; i++)
        begin
            ra = $random(seed);
            rd = $random(seed);
            go(`NVSC_CMD_WRITE, ra, rd, 10'h000);
            go(`NVSC_CMD_READ, ra, 8'h00, {2'b10, rd});
        end
        go(`NVSC_CMD_WRITE, 15'h4100, 8'h5a, 10'h000);
        go(`NVSC_CMD_SAVE, 15'h0000, 8'h00, 10'h000);
        go(`NVSC_CMD_WRITE, 15'h4100, 8'ha5, 10'h000);
        go(`NVSC_CMD_READ, 15'h4100, 8'h00, {2'b10, 8'ha5});
        go(`NVSC_CMD_RELOAD, 15'h0000, 8'h00, 10'h000);
        go(`NVSC_CMD_READ, 15'h4100, 8'h00, {2'b10, 8'h5a});
        low_supply_i <= 1'b1;
        go(`NVSC_CMD_WRITE, 15'h4100, 8'h33, 10'h100);
        go(`NVSC_CMD_SAVE, 15'h0000, 8'h00, 10'h100);
        go(`NVSC_CMD_READ, 15'h4100, 8'h00, {2'b10, 8'h5a});
        go(`NVSC_CMD_RELOAD, 15'h0000, 8'h00, 10'h000);
        low_supply_i <= 1'b0;
        go(`NVSC_CMD_READ, 15'h4100, 8'h00, {2'b10, 8'h5a});
        while (exp_q.size() > 0)
            @(posedge mclk_i);
        give_verdict;
    end
endmodule
`default_nettype wire
